// >>> hw/tmrb_core.sv
/*
  16-bit timer counter register block: flags, run status, debug halt, shared byte latch,
  counter and capture compare register, reached over an axi4-lite slave.
  assumes: event_in and debug_halt come from outside the clock domain; single clock aclk.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
// Functional notes
// RL1: wrap flag with enable requests interrupt
// RL2: event flag with enable requests interrupt
// RL3: wrap flag sets when counter wraps
// RL4: write one clears wrap flag; zero ignored
// RL5: event flag cleared by write or capture read
// RL6: top match sets event flag
// RL7: frequency mode: capture, restart, set flag
// RL8: capture mode: capture, set flag, keep counting
// RL9: pulse width: restart edge, capture edge
// RL10: combined mode: second edge stops, sets flag
// RL11: pwm: low byte top, high byte flag
// RL12: status bit shows running, read only
// RL13: debug halt freezes unless keep running
// RL14: one shared byte latch for wide access
// RL15: counter as low and high bytes
// RL16: bus write beats counter update
// RL17: capture modes hold captured count
// RL18: timer modes use compare as top
// RL19: pwm bytes give period and duty
// RL20: three bit mode field selects mode
// RL21: low read latches high; low write commits
`include "tmrb_regs.svh"

module tmrb_core #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  event_in,
  input  wire logic                  debug_halt,
  output      logic                  irq_request
);

  logic                   aw_held_reg, w_held_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [5:0]             aw_idx_reg;
  logic [7:0]             w_byte_reg;
  logic                   w_strb_reg;
  logic [1:0]             bresp_reg, rresp_reg;
  logic [31:0]            rdata_reg;
  logic [7:0]             irq_enable_reg, halt_behaviour_reg, wide_access_latch;
  logic                   wrap_flag_reg, event_latch_flag_reg, run_reg, irq_reg;
  logic [15:0]            count_value_reg, match_value_reg, count_next, match_next;
  tmrb_pkg::tmrb_setup_type setup_reg;
  tmrb_pkg::tmrb_phase_type phase_reg, phase_next;
  logic                   active_reg, active_next;
  logic                   ev_sync1_reg, ev_sync2_reg, ev_prev_reg, halt_sync1_reg, halt_sync2_reg;
  logic                   freeze, counting, ev_rise, ev_fall, ev_a, ev_b, wrap_set, event_set;
  logic                   wr_fire, rd_fire, wr_lo, ev_start;
  logic [5:0]             wr_idx, rd_idx;
  logic [7:0]             wr_byte, match_lo, match_hi;
  logic                   mode_capture;
  tmrb_pkg::tmrb_mode_type mode;

  // bus outputs from flops; awready and wready gated by the held latches and bvalid
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq_request   = irq_reg;

  // decoded write and read strobes
  assign wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_idx   = aw_idx_reg;
  assign wr_byte  = w_byte_reg;
  assign wr_lo    = wr_fire & w_strb_reg;
  assign rd_fire  = s_axi_arvalid & arready_reg;
  assign rd_idx   = s_axi_araddr[7:2];
  assign mode     = setup_reg.timer_mode_select;
  assign match_lo = match_value_reg[7:0];
  assign match_hi = match_value_reg[15:8];
  assign mode_capture = (mode == tmrb_pkg::TMRB_CAPTURE) | (mode == tmrb_pkg::TMRB_FREQ) |
                        (mode == tmrb_pkg::TMRB_PULSE_WIDTH) | (mode == tmrb_pkg::TMRB_FREQ_PW);

  // write address and data latches, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_byte_reg  <= `TMRB_RST_BYTE;
      w_strb_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[7:2];
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, error for unmapped or read-only words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `TMRB_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      case (wr_idx)
        `TMRB_IDX_IRQ_ENABLE, `TMRB_IDX_IRQ_PENDING, `TMRB_IDX_HALT_BEHAV, `TMRB_IDX_WIDE_LATCH,
        `TMRB_IDX_COUNT_LO, `TMRB_IDX_COUNT_HI, `TMRB_IDX_MATCH_LO, `TMRB_IDX_MATCH_HI,
        `TMRB_IDX_SETUP: bresp_reg <= `TMRB_RESP_OKAY;
        default:         bresp_reg <= `TMRB_RESP_SLVERR; // see RL12
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel: one word at a time, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `TMRB_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= `TMRB_RESP_OKAY;
      case (rd_idx)
        `TMRB_IDX_IRQ_ENABLE:  rdata_reg <= {24'h000000, irq_enable_reg};
        `TMRB_IDX_IRQ_PENDING: rdata_reg <= {30'h00000000, wrap_flag_reg, event_latch_flag_reg};
        `TMRB_IDX_RUN_STATE:   rdata_reg <= {31'h00000000, run_reg}; // see RL12
        `TMRB_IDX_HALT_BEHAV:  rdata_reg <= {24'h000000, halt_behaviour_reg};
        `TMRB_IDX_WIDE_LATCH:  rdata_reg <= {24'h000000, wide_access_latch}; // see RL14
        `TMRB_IDX_COUNT_LO:    rdata_reg <= {24'h000000, count_value_reg[7:0]}; // see RL15
        `TMRB_IDX_MATCH_LO:    rdata_reg <= {24'h000000, match_lo}; // see RL17
        `TMRB_IDX_COUNT_HI,
        `TMRB_IDX_MATCH_HI:    rdata_reg <= {24'h000000, wide_access_latch}; // see RL21
        `TMRB_IDX_SETUP:       rdata_reg <= {24'h000000, setup_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `TMRB_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg) begin
      if (s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end else begin
      arready_reg <= 1'b1;
    end
  end

  // two-flop synchronisers for the pins, edge detect after the second flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_sync1_reg   <= 1'b0;
      ev_sync2_reg   <= 1'b0;
      ev_prev_reg    <= 1'b0;
      halt_sync1_reg <= 1'b0;
      halt_sync2_reg <= 1'b0;
    end else begin
      ev_sync1_reg   <= event_in;
      ev_sync2_reg   <= ev_sync1_reg;
      ev_prev_reg    <= ev_sync2_reg;
      halt_sync1_reg <= debug_halt;
      halt_sync2_reg <= halt_sync1_reg;
    end
  end

  // qualified edges; a is the selected polarity, b the opposite one
  assign freeze   = halt_sync2_reg & ~halt_behaviour_reg[`TMRB_BIT_KEEP_RUN]; // see RL13
  assign ev_rise  = ev_sync2_reg & ~ev_prev_reg & setup_reg.event_enable & setup_reg.enable & ~freeze;
  assign ev_fall  = ~ev_sync2_reg & ev_prev_reg & setup_reg.event_enable & setup_reg.enable & ~freeze;
  assign ev_a     = setup_reg.edge_select ? ev_fall : ev_rise;
  assign ev_b     = setup_reg.edge_select ? ev_rise : ev_fall;
  assign ev_start = ev_a | (setup_reg.edge_select & ev_b);
  assign counting = setup_reg.enable & ~freeze & (active_reg | (mode == tmrb_pkg::TMRB_PERIODIC) |
                    (mode == tmrb_pkg::TMRB_CAPTURE) | (mode == tmrb_pkg::TMRB_FREQ) |
                    (mode == tmrb_pkg::TMRB_PULSE_WIDTH) | (mode == tmrb_pkg::TMRB_PWM8));

  // counting step first, then event actions override it
  always_comb begin
    count_next  = count_value_reg;
    match_next  = match_value_reg;
    active_next = setup_reg.enable ? active_reg : 1'b0;
    phase_next  = setup_reg.enable ? phase_reg : tmrb_pkg::TMRB_PH_ARM;
    wrap_set    = 1'b0;
    event_set   = 1'b0;
    if (counting) begin
      case (mode)
        tmrb_pkg::TMRB_PERIODIC, tmrb_pkg::TMRB_TIMEOUT, tmrb_pkg::TMRB_SINGLE: begin
          if (count_value_reg == match_value_reg) begin
            event_set  = 1'b1; // see RL6
            count_next = `TMRB_RST_WORD; // see RL18
            if (mode == tmrb_pkg::TMRB_SINGLE) begin
              active_next = 1'b0;
            end
          end else begin
            count_next = count_value_reg + 16'h0001;
            wrap_set   = (count_value_reg == `TMRB_COUNT_MAX); // see RL3
          end
        end
        tmrb_pkg::TMRB_PWM8: begin
          event_set = (count_value_reg[7:0] == match_hi); // see RL11
          if (count_value_reg[7:0] == match_lo) begin
            count_next = `TMRB_RST_WORD; // see RL19
            wrap_set   = 1'b1; // see RL3
          end else begin
            count_next = {8'h00, count_value_reg[7:0] + 8'h01};
          end
        end
        default: begin
          count_next = count_value_reg + 16'h0001;
          wrap_set   = (count_value_reg == `TMRB_COUNT_MAX); // see RL3
        end
      endcase
    end
    case (mode) // see RL20
      tmrb_pkg::TMRB_TIMEOUT: begin
        if (ev_a) begin
          active_next = 1'b1;
        end else if (ev_b) begin
          active_next = 1'b0;
        end
      end
      tmrb_pkg::TMRB_CAPTURE: begin
        if (ev_a) begin
          match_next = count_value_reg; // see RL8
          event_set  = 1'b1;
        end
      end
      tmrb_pkg::TMRB_FREQ: begin
        if (ev_a) begin
          match_next = count_value_reg; // see RL7
          count_next = `TMRB_RST_WORD;
          event_set  = 1'b1;
        end
      end
      tmrb_pkg::TMRB_PULSE_WIDTH: begin
        if (ev_a) begin
          count_next = `TMRB_RST_WORD; // see RL9
        end else if (ev_b) begin
          match_next = count_value_reg; // see RL9
          event_set  = 1'b1;
        end
      end
      tmrb_pkg::TMRB_FREQ_PW: begin
        case (phase_reg)
          tmrb_pkg::TMRB_PH_ARM: begin
            if (ev_a) begin
              count_next  = `TMRB_RST_WORD;
              active_next = 1'b1;
              phase_next  = tmrb_pkg::TMRB_PH_MEASURE;
            end
          end
          tmrb_pkg::TMRB_PH_MEASURE: begin
            if (ev_b) begin
              match_next = count_value_reg; // see RL17
            end else if (ev_a) begin
              active_next = 1'b0; // see RL10
              event_set   = 1'b1;
              phase_next  = tmrb_pkg::TMRB_PH_DONE;
            end
          end
          tmrb_pkg::TMRB_PH_DONE: begin
            if (!event_latch_flag_reg) begin
              phase_next = tmrb_pkg::TMRB_PH_ARM;
            end
          end
          default: phase_next = tmrb_pkg::TMRB_PH_ARM;
        endcase
      end
      tmrb_pkg::TMRB_SINGLE: begin
        if (ev_start && !active_reg) begin
          active_next = 1'b1;
          count_next  = `TMRB_RST_WORD;
        end
      end
      default: begin
      end
    endcase
  end

  // counter and compare registers; bus writes take precedence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value_reg <= `TMRB_RST_WORD;
      match_value_reg <= `TMRB_RST_WORD;
      active_reg      <= 1'b0;
      phase_reg       <= tmrb_pkg::TMRB_PH_ARM;
      run_reg         <= 1'b0;
    end else begin
      active_reg <= active_next;
      phase_reg  <= phase_next;
      run_reg    <= counting; // see RL12
      if (wr_lo && wr_idx == `TMRB_IDX_COUNT_LO) begin
        count_value_reg <= {wide_access_latch, wr_byte}; // see RL16
      end else begin
        count_value_reg <= count_next;
      end
      if (wr_lo && wr_idx == `TMRB_IDX_MATCH_LO) begin
        match_value_reg <= {wide_access_latch, wr_byte}; // see RL21
      end else begin
        match_value_reg <= match_next;
      end
    end
  end

  // shared byte latch: high-byte writes, direct writes, low-byte reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_access_latch <= `TMRB_RST_BYTE;
    end else if (wr_lo && (wr_idx == `TMRB_IDX_WIDE_LATCH || wr_idx == `TMRB_IDX_COUNT_HI ||
                 wr_idx == `TMRB_IDX_MATCH_HI)) begin
      wide_access_latch <= wr_byte; // see RL14
    end else if (rd_fire && rd_idx == `TMRB_IDX_COUNT_LO) begin
      wide_access_latch <= count_value_reg[15:8]; // see RL21
    end else if (rd_fire && rd_idx == `TMRB_IDX_MATCH_LO) begin
      wide_access_latch <= match_hi; // see RL21
    end
  end

  // plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg     <= `TMRB_RST_BYTE;
      halt_behaviour_reg <= `TMRB_RST_BYTE;
      setup_reg          <= tmrb_pkg::tmrb_setup_type'(`TMRB_RST_BYTE);
    end else if (wr_lo) begin
      if (wr_idx == `TMRB_IDX_IRQ_ENABLE) begin
        irq_enable_reg <= wr_byte;
      end
      if (wr_idx == `TMRB_IDX_HALT_BEHAV) begin
        halt_behaviour_reg <= wr_byte;
      end
      if (wr_idx == `TMRB_IDX_SETUP) begin
        setup_reg <= tmrb_pkg::tmrb_setup_type'(wr_byte);
      end
    end
  end

  // sticky flags: set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag_reg        <= 1'b0;
      event_latch_flag_reg <= 1'b0;
    end else begin
      wrap_flag_reg <= wrap_set | (wrap_flag_reg &
        ~(wr_lo && wr_idx == `TMRB_IDX_IRQ_PENDING && wr_byte[`TMRB_BIT_WRAP])); // see RL4
      event_latch_flag_reg <= event_set | (event_latch_flag_reg &
        ~(wr_lo && wr_idx == `TMRB_IDX_IRQ_PENDING && wr_byte[`TMRB_BIT_EVENT]) &
        ~(rd_fire && rd_idx == `TMRB_IDX_MATCH_LO && mode_capture)); // see RL5
    end
  end

  // interrupt request from flags and enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (wrap_flag_reg & irq_enable_reg[`TMRB_BIT_WRAP]) | // see RL1
                 (event_latch_flag_reg & irq_enable_reg[`TMRB_BIT_EVENT]); // see RL2
    end
  end

  // checks
  property p_wrap_irq;
    @(posedge aclk) disable iff (!aresetn)
    (wrap_flag_reg && irq_enable_reg[`TMRB_BIT_WRAP]) |=> irq_request;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap interrupt missing"); // see RL1
  property p_event_irq;
    @(posedge aclk) disable iff (!aresetn)
    (event_latch_flag_reg && irq_enable_reg[`TMRB_BIT_EVENT]) |=> irq_request;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("event interrupt missing"); // see RL2
  property p_wrap_sets;
    @(posedge aclk) disable iff (!aresetn)
    (counting && mode == tmrb_pkg::TMRB_CAPTURE && count_value_reg == `TMRB_COUNT_MAX) |=> wrap_flag_reg;
  endproperty
  a_wrap_sets: assert property (p_wrap_sets) else $error("wrap flag not set"); // see RL3
  property p_zero_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (wrap_flag_reg && wr_fire && wr_idx == `TMRB_IDX_IRQ_PENDING && !wr_byte[`TMRB_BIT_WRAP])
      |=> wrap_flag_reg;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("wrap flag lost on zero write"); // see RL4
  property p_capture_read_clears;
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && rd_idx == `TMRB_IDX_MATCH_LO && mode_capture && !event_set) |=> !event_latch_flag_reg;
  endproperty
  a_capture_read_clears: assert property (p_capture_read_clears) else $error("flag kept after read"); // see RL5
  property p_freq_restart;
    @(posedge aclk) disable iff (!aresetn)
    (mode == tmrb_pkg::TMRB_FREQ && ev_a && !wr_lo) |=>
      (count_value_reg == `TMRB_RST_WORD && event_latch_flag_reg);
  endproperty
  a_freq_restart: assert property (p_freq_restart) else $error("frequency restart wrong"); // see RL7
  property p_capture_load;
    @(posedge aclk) disable iff (!aresetn)
    (mode == tmrb_pkg::TMRB_CAPTURE && ev_a && !wr_lo) |=>
      (match_value_reg == $past(count_value_reg) && event_latch_flag_reg);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture value wrong"); // see RL8
  property p_debug_freeze;
    @(posedge aclk) disable iff (!aresetn)
    (freeze && !wr_lo) |=> (count_value_reg == $past(count_value_reg) && !run_reg);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("counter moved while halted"); // see RL13
  property p_write_wins;
    @(posedge aclk) disable iff (!aresetn)
    (wr_lo && wr_idx == `TMRB_IDX_COUNT_LO) |=>
      (count_value_reg == {$past(wide_access_latch), $past(wr_byte)});
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost"); // see RL16
  property p_low_read_latch;
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && rd_idx == `TMRB_IDX_COUNT_LO && !wr_lo) |=> (wide_access_latch == $past(count_value_reg[15:8]));
  endproperty
  a_low_read_latch: assert property (p_low_read_latch) else $error("high byte not latched"); // see RL21
  c_periodic_top: cover property (@(posedge aclk) disable iff (!aresetn)
    mode == tmrb_pkg::TMRB_PERIODIC && event_set);
  c_pwm_duty: cover property (@(posedge aclk) disable iff (!aresetn)
    mode == tmrb_pkg::TMRB_PWM8 && event_set ##1 irq_request);
  c_freq_pw_done: cover property (@(posedge aclk) disable iff (!aresetn)
    phase_reg == tmrb_pkg::TMRB_PH_DONE);

endmodule : tmrb_core

// >>> inc/tmrb_pkg.sv
/*
  types of the timer register block: mode codes and the software setup word.
  assumes: the constants header supplies all numeric offsets and fields.
*/
package tmrb_pkg;

  // counting modes, coded zero to seven in this order
  typedef enum logic [2:0] {
    TMRB_PERIODIC,
    TMRB_TIMEOUT,
    TMRB_CAPTURE,
    TMRB_FREQ,
    TMRB_PULSE_WIDTH,
    TMRB_FREQ_PW,
    TMRB_SINGLE,
    TMRB_PWM8
  } tmrb_mode_type;

  // setup register, packed msb first: bits 7:6 spare, 5 event enable, 4 edge, 3:1 mode, 0 enable
  typedef struct packed {
    logic [1:0]    spare;
    logic          event_enable;
    logic          edge_select;
    tmrb_mode_type timer_mode_select;
    logic          enable;
  } tmrb_setup_type;

  // phases of the combined frequency and pulse-width measurement
  typedef enum logic [1:0] {
    TMRB_PH_ARM,
    TMRB_PH_MEASURE,
    TMRB_PH_DONE
  } tmrb_phase_type;

endpackage : tmrb_pkg

// >>> inc/tmrb_regs.svh
/*
  register indices, field positions and reset values of the timer register block.
  assumes: one byte register per aligned 32-bit bus word, byte address is four times the index.
*/
`ifndef TMRB_REGS_SVH
`define TMRB_REGS_SVH

// register indices
`define TMRB_IDX_IRQ_ENABLE   6'h05
`define TMRB_IDX_IRQ_PENDING  6'h06
`define TMRB_IDX_RUN_STATE    6'h07
`define TMRB_IDX_HALT_BEHAV   6'h08
`define TMRB_IDX_WIDE_LATCH   6'h09
`define TMRB_IDX_COUNT_LO     6'h0a
`define TMRB_IDX_COUNT_HI     6'h0b
`define TMRB_IDX_MATCH_LO     6'h0c
`define TMRB_IDX_MATCH_HI     6'h0d
`define TMRB_IDX_SETUP        6'h10

// field positions
`define TMRB_BIT_WRAP         1
`define TMRB_BIT_EVENT        0
`define TMRB_BIT_KEEP_RUN     0
`define TMRB_BIT_RUNNING      0
`define TMRB_BIT_ENABLE       0
`define TMRB_LSB_MODE         1
`define TMRB_MSB_MODE         3
`define TMRB_BIT_EDGE         4
`define TMRB_BIT_EVENT_EN     5

// reset values and counter limits
`define TMRB_RST_BYTE         8'h00
`define TMRB_RST_WORD         16'h0000
`define TMRB_COUNT_MAX        16'hffff

// bus responses
`define TMRB_RESP_OKAY        2'b00
`define TMRB_RESP_SLVERR      2'b10

`endif

// >>> test/tb_tmrb_core.sv
/*
  self-checking bench of the timer register block: register table, flags, modes, debug halt.
  assumes: tmrb_core with its default address width, one 125 mhz clock, header on the include path.
*/
`include "tmrb_regs.svh"

module tb_tmrb_core;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [5:0] i;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] b;
    logic [1:0] r;
  } tmrb_row_type;

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awa     = 8'h00;
  logic [7:0]  ara     = 8'h00;
  logic [31:0] wd      = 32'h0;
  logic        awv     = 1'b0;
  logic        wv      = 1'b0;
  logic        br      = 1'b0;
  logic        arv     = 1'b0;
  logic        rr      = 1'b0;
  logic        ev      = 1'b0;
  logic        dh      = 1'b0;
  logic        awr, wrdy, bv, arr, rv, irq;
  logic [1:0]  bresp, rresp, e;
  logic [31:0] rdt, q, cap;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc      = 0;

  // register table rows: index, written byte, expected read, write and read responses
  localparam tmrb_row_type rows [5] = '{
    '{`TMRB_IDX_IRQ_ENABLE, 8'h03, 8'h03, `TMRB_RESP_OKAY, `TMRB_RESP_OKAY},
    '{`TMRB_IDX_HALT_BEHAV, 8'h01, 8'h01, `TMRB_RESP_OKAY, `TMRB_RESP_OKAY},
    '{`TMRB_IDX_WIDE_LATCH, 8'ha5, 8'ha5, `TMRB_RESP_OKAY, `TMRB_RESP_OKAY},
    '{`TMRB_IDX_RUN_STATE, 8'h01, 8'h00, `TMRB_RESP_SLVERR, `TMRB_RESP_OKAY},
    '{6'h01, 8'hff, 8'h00, `TMRB_RESP_SLVERR, `TMRB_RESP_SLVERR}};

  tmrb_core DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .event_in(ev), .debug_halt(dh), .irq_request(irq));

  // clock and hang guard
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one axi write; ready and response are sampled at the rising edge that takes them
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    @(posedge aclk);
    awa <= {i, 2'b00};
    wd  <= {24'h0, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      e = bresp;
    end while (!bv);
    br <= 1'b0;
  endtask : wr

  // one axi read, data left in q and response in e
  task automatic rd(input logic [5:0] i);
    @(posedge aclk);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    rr  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      q = rdt;
      e = rresp;
    end while (!rv);
    rr <= 1'b0;
  endtask : rd

  task automatic wirq(input logic x);
    int n;
    n = 0;
    while (irq !== x && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk(irq, x);
  endtask : wirq

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int j = 5; j < 14; j++) begin
      rd(j[5:0]);
      chk(q, 32'h0);
    end
    foreach (rows[j]) begin
      wr(rows[j].i, rows[j].d);
      chk(e, rows[j].b);
      rd(rows[j].i);
      chk(q, rows[j].q);
      chk(e, rows[j].r);
    end
    // wide access through the shared byte: top 0x0010, count 0xfff0
    wr(`TMRB_IDX_HALT_BEHAV, 8'h00);
    wr(`TMRB_IDX_MATCH_HI, 8'h00);
    wr(`TMRB_IDX_MATCH_LO, 8'h10);
    rd(`TMRB_IDX_MATCH_LO);
    chk(q, 32'h10);
    wr(`TMRB_IDX_COUNT_HI, 8'hff);
    wr(`TMRB_IDX_COUNT_LO, 8'hf0);
    rd(`TMRB_IDX_COUNT_LO);
    rd(`TMRB_IDX_COUNT_HI);
    chk(q, 32'hff);
    // periodic mode crossing the maximum raises the wrap request
    wr(`TMRB_IDX_IRQ_ENABLE, 8'h02);
    wr(`TMRB_IDX_SETUP, 8'h01);
    wirq(1'b1);
    wr(`TMRB_IDX_SETUP, 8'h00);
    wr(`TMRB_IDX_IRQ_PENDING, 8'h00);
    rd(`TMRB_IDX_IRQ_PENDING);
    chk(q & 32'h2, 32'h2);
    wr(`TMRB_IDX_IRQ_PENDING, 8'h02);
    rd(`TMRB_IDX_IRQ_PENDING);
    chk(q & 32'h2, 32'h0);
    wirq(1'b0);
    // top match in periodic mode keeps the count at or below the top
    wr(`TMRB_IDX_IRQ_PENDING, 8'h03);
    wr(`TMRB_IDX_IRQ_ENABLE, 8'h01);
    wr(`TMRB_IDX_SETUP, 8'h01);
    wirq(1'b1);
    repeat (100) @(posedge aclk);
    wr(`TMRB_IDX_SETUP, 8'h00);
    rd(`TMRB_IDX_COUNT_LO);
    chk(q <= 32'h10, 32'h1);
    // capture on a rising event, then the falling edge must not capture
    wr(`TMRB_IDX_IRQ_PENDING, 8'h03);
    wirq(1'b0);
    wr(`TMRB_IDX_SETUP, 8'h25);
    rd(`TMRB_IDX_RUN_STATE);
    chk(q, 32'h1);
    ev <= 1'b1;
    wirq(1'b1);
    rd(`TMRB_IDX_MATCH_LO);
    cap = q;
    rd(`TMRB_IDX_IRQ_PENDING);
    chk(q, 32'h0);
    rd(`TMRB_IDX_COUNT_LO);
    chk(q > cap, 32'h1);
    ev <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(irq, 1'b0);
    // frequency mode: a rising event restarts the count and sets the flag
    wr(`TMRB_IDX_SETUP, 8'h27);
    ev <= 1'b1;
    wirq(1'b1);
    rd(`TMRB_IDX_COUNT_LO);
    chk(q < 32'h20, 32'h1);
    rd(`TMRB_IDX_MATCH_LO);
    rd(`TMRB_IDX_IRQ_PENDING);
    chk(q, 32'h0);
    ev <= 1'b0;
    // pwm: period 0x20 in the low byte, duty 0x08 in the high byte
    wr(`TMRB_IDX_MATCH_HI, 8'h08);
    wr(`TMRB_IDX_MATCH_LO, 8'h20);
    wr(`TMRB_IDX_SETUP, 8'h0f);
    wr(`TMRB_IDX_IRQ_PENDING, 8'h03);
    wirq(1'b1);
    rd(`TMRB_IDX_COUNT_LO);
    chk(q <= 32'h20, 32'h1);
    wr(`TMRB_IDX_SETUP, 8'h00);
    wr(`TMRB_IDX_IRQ_PENDING, 8'h03);
    // debug halt clears the run status unless told to keep running
    dh <= 1'b1;
    wr(`TMRB_IDX_SETUP, 8'h01);
    rd(`TMRB_IDX_RUN_STATE);
    chk(q, 32'h0);
    wr(`TMRB_IDX_HALT_BEHAV, 8'h01);
    rd(`TMRB_IDX_RUN_STATE);
    chk(q, 32'h1);
    // reset in mid-run brings every register back to zero
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(irq, 1'b0);
    rd(`TMRB_IDX_IRQ_ENABLE);
    chk(q, 32'h0);
    rd(`TMRB_IDX_COUNT_LO);
    chk(q, 32'h0);
    stop_test();
  end
endmodule : tb_tmrb_core
